// ---- verilog/lsal_status.sv ----
// Sticky limit status registers and the active-low alert output.
// Assumes out-of-limit flags and register reads arrive on sys_clk; pins are synchronised here.
//
// Notes on behaviour
// R1 - An out-of-limit channel sets its status bit to 1.
// R2 - A set bit stays set until the host reads its register.
// R3 - A read clears a bit only if its condition has gone.
// R4 - Primary bit 7 reads 1 while any secondary bit is set.
// R5 - Primary bits 6..0: remote two, local, remote one, 5 V, supply, core, 2.5 V.
// R6 - With thermal alarm on the 2.5 V pin, primary bit 0 shows that pin.
// R7 - Secondary bits 7 and 6 flag remote two and remote one diode faults.
// R8 - Secondary bit 5 follows the selected shared fourth pin function.
// R9 - Secondary bits 4, 3, 2 flag fans three, two, one slow.
// R10 - Secondary bit 1 is overtemperature, not sticky, clears when condition ends.
// R11 - Secondary bit 0 flags 12 V limits, or a voltage-ID change when selected.
// R12 - Masked sources still set their status bits.
// R13 - Alert stays low while unmasked source out, and until read.
// R14 - Either of two pins may carry the alert output.
// R15 - Polling host reads status periodically to see every sticky event.
// R16 - Out of limit means above high limit or at or below low limit.
// R17 - Reads return pre-clear values; same-cycle events still set bits.
// R18 - Alert releases when no unmasked bit is set and no source is out.
`timescale 1ns/100ps
`default_nettype none
module lsal_status (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic [6:0]                primary_out_of_limit,
    input  wire logic                      remote_two_diode_fault,
    input  wire logic                      remote_one_diode_fault,
    input  wire logic [2:0]                fan_slow,
    input  wire logic                      fan_four_slow,
    input  wire logic                      thermal_limit_exceeded,
    input  wire logic                      overtemperature_flag,
    input  wire logic                      twelve_volt_out_of_limit,
    input  wire logic                      thermal_alarm_pin_n,
    input  wire logic                      general_purpose_pin_six,
    input  wire logic [4:0]                voltage_id,
    input  wire logic                      thermal_on_volt25_pin,
    input  wire logic                      id_change_select,
    input  wire lsal_pkg::lsal_pin4_type   pin4_function,
    input  wire logic                      pin10_alert_select,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    output logic      [7:0]                reg_rdata,
    output logic                           pin10_alert_n,
    output logic                           pin14_alert_n
);
    import lsal_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic       alarm_meta_q, alarm_sync_q, gp_meta_q, gp_sync_q;
    logic [4:0] vid_meta_q, vid_sync_q, vid_last_q;
    logic       vid_primed_q;

    always_ff @(posedge sys_clk) begin
        alarm_meta_q <= ~thermal_alarm_pin_n;
        alarm_sync_q <= alarm_meta_q;
        gp_meta_q    <= general_purpose_pin_six;
        gp_sync_q    <= gp_meta_q;
        vid_meta_q   <= voltage_id;
        vid_sync_q   <= vid_meta_q;
    end

    // First sample after reset only primes the reference, so no false change
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vid_last_q   <= LSAL_VID_RESET;
            vid_primed_q <= 1'b0;
        end else begin
            vid_last_q   <= vid_sync_q;
            vid_primed_q <= 1'b1;
        end
    end

    // ****************************************
    // Source selection
    // ****************************************
    logic [7:0] prim_cond, sec_cond;
    logic       shared4_cond, vid_change;

    assign vid_change = vid_primed_q && (vid_sync_q != vid_last_q);

    always_comb begin
        case (pin4_function) // R8
            LSAL_PIN4_TACH:    shared4_cond = fan_four_slow;
            LSAL_PIN4_THERMAL: shared4_cond = thermal_limit_exceeded;
            LSAL_PIN4_GENERAL: shared4_cond = gp_sync_q;
            default:           shared4_cond = 1'b0;
        endcase
    end

    // Comparators upstream apply strict-above-high, at-or-below-low  // R16
    always_comb begin
        prim_cond = {1'b0, primary_out_of_limit}; // R5
        if (thermal_on_volt25_pin) begin
            prim_cond[LSAL_VOLT25_BIT] = alarm_sync_q; // R6
        end
        sec_cond = {remote_two_diode_fault, remote_one_diode_fault, shared4_cond,
                    fan_slow[2], fan_slow[1], fan_slow[0], 1'b0,
                    id_change_select ? vid_change : twelve_volt_out_of_limit}; // R7 R9 R11
    end

    // ****************************************
    // Sticky status bits
    // ****************************************
    logic [7:0] prim_q, sec_q, mask1_q, mask2_q;
    logic       rd_prim, rd_sec;
    logic [7:0] sec_view;

    assign rd_prim  = reg_rd && (reg_addr == LSAL_PRIMARY_OFFSET);
    assign rd_sec   = reg_rd && (reg_addr == LSAL_SECONDARY_OFFSET);
    assign sec_view = {sec_q[7:2], overtemperature_flag, sec_q[0]}; // R10

    // Set wins over the read-clear; a read drops only bits whose source is gone
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prim_q <= LSAL_STATUS_RESET;
        end else if (rd_prim) begin
            prim_q <= prim_cond; // R3 R17
        end else begin
            prim_q <= prim_q | prim_cond; // R1 R2 R12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sec_q <= LSAL_STATUS_RESET;
        end else if (rd_sec) begin
            sec_q <= sec_cond; // R3 R17
        end else begin
            sec_q <= sec_q | sec_cond; // R1 R2
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask1_q <= LSAL_MASK_RESET;
            mask2_q <= LSAL_MASK_RESET;
        end else if (reg_wr) begin
            if (reg_addr == LSAL_MASK1_OFFSET) mask1_q <= reg_wdata;
            if (reg_addr == LSAL_MASK2_OFFSET) mask2_q <= reg_wdata;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                LSAL_PRIMARY_OFFSET:   reg_rdata <= {|sec_view, prim_q[6:0]}; // R4 R17
                LSAL_SECONDARY_OFFSET: reg_rdata <= sec_view;
                LSAL_MASK1_OFFSET:     reg_rdata <= mask1_q;
                LSAL_MASK2_OFFSET:     reg_rdata <= mask2_q;
                default:               reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Alert output
    // ****************************************
    logic sec_alert, alert;

    // Live conditions are ORed in so a masked read never hides a standing fault
    assign sec_alert = |((sec_view | sec_cond) & ~mask2_q);
    assign alert     = |((prim_q[6:0] | prim_cond[6:0]) & ~mask1_q[6:0])
                       | (sec_alert & ~mask1_q[LSAL_PENDING_BIT]); // R13 R18

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin10_alert_n <= 1'b1;
            pin14_alert_n <= 1'b1;
        end else begin
            pin10_alert_n <= ~(alert & pin10_alert_select); // R14
            pin14_alert_n <= ~(alert && pin4_function == LSAL_PIN4_ALERT); // R14
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence set_seen_s;
        !rst && !rd_prim && prim_cond[4];
    endsequence

    sticky_set_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
        set_seen_s |=> prim_q[4]) else $error("status bit not set by condition");
    sticky_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
        prim_q[3] && !rd_prim |=> prim_q[3]) else $error("sticky bit lost without read");
    read_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // R3
        rd_sec && !sec_cond[6] |=> !sec_q[6]) else $error("read did not clear gone bit");
    read_keep_a: assert property (@(posedge sys_clk) disable iff (rst) // R17
        rd_prim && prim_cond[2] |=> prim_q[2]) else $error("standing condition cleared");
    pending_bit_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
        rd_prim && (|sec_view) |=> reg_rdata[7]) else $error("pending bit not shown");
    overtemp_live_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
        rd_sec |=> reg_rdata[1] == $past(overtemperature_flag)) else $error("overtemp not live");
    sequence live_fault_s;
        pin10_alert_select && |(prim_cond[6:0] & ~mask1_q[6:0]);
    endsequence

    alert_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
        live_fault_s ##1 pin10_alert_select
        |-> !pin10_alert_n) else $error("alert not asserted");
    alert_release_a: assert property (@(posedge sys_clk) disable iff (rst) // R18
        !alert |=> pin10_alert_n && pin14_alert_n) else $error("alert not released");

    // A change lasts one cycle only, so the sticky bit is the only record of it
    sequence vid_step_s;
        id_change_select && vid_change;
    endsequence

    masked_set_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
        mask1_q[3] && prim_cond[3] |=> prim_q[3]) else $error("masked source did not set bit");
    alarm_bit_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
        thermal_on_volt25_pin && alarm_sync_q |=> prim_q[LSAL_VOLT25_BIT])
        else $error("alarm pin not flagged");
    shared_tach_a: assert property (@(posedge sys_clk) disable iff (rst) // R8
        pin4_function == LSAL_PIN4_TACH && fan_four_slow |=> sec_q[LSAL_SHARED4_BIT])
        else $error("fan four not flagged");
    vid_change_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
        vid_step_s |=> sec_q[LSAL_TWELVE_BIT]) else $error("id change not flagged");
    pin14_alert_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
        alert && pin4_function == LSAL_PIN4_ALERT |=> !pin14_alert_n)
        else $error("shared pin alert missing");
endmodule
`default_nettype wire

// ---- verilog/lsal_pkg.sv ----
// Package for the limit status and alert logic.
// Assumes a single device clock; register offsets are the device register addresses.
package lsal_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] LSAL_PRIMARY_OFFSET   = 8'h41;
    localparam logic [7:0] LSAL_SECONDARY_OFFSET = 8'h42;
    localparam logic [7:0] LSAL_MASK1_OFFSET     = 8'h74;
    localparam logic [7:0] LSAL_MASK2_OFFSET     = 8'h75;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int LSAL_PENDING_BIT   = 7;
    localparam int LSAL_VOLT25_BIT    = 0;
    localparam int LSAL_SHARED4_BIT   = 5;
    localparam int LSAL_OVERTEMP_BIT  = 1;
    localparam int LSAL_TWELVE_BIT    = 0;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] LSAL_STATUS_RESET = 8'h00;
    localparam logic [7:0] LSAL_MASK_RESET   = 8'h00;
    localparam logic [4:0] LSAL_VID_RESET    = 5'h00;
    // ****************************************
    // Shared fourth tachometer pin functions
    // ****************************************
    typedef enum logic [1:0] {
        LSAL_PIN4_TACH    = 2'h0,
        LSAL_PIN4_THERMAL = 2'h1,
        LSAL_PIN4_ALERT   = 2'h2,
        LSAL_PIN4_GENERAL = 2'h3
    } lsal_pin4_type;
endpackage

// ---- bench/lsal_host.sv ----
// Host model that polls and programs the status block over its register strobes.
// Assumes one sys_clk domain; requests launch on a rising edge by non-blocking assignment.
`timescale 1ns/100ps
`default_nettype none
module lsal_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    import lsal_pkg::*;
    initial begin
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // Periodic polling reads; data taken the edge after the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 data = reg_rdata;
    endtask
    // Data lines flip once released so a stale value never looks valid
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~data;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the sticky status registers and alert output.
// Assumes lsal_pkg and lsal_status are compiled first; the host model drives the strobes.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import lsal_pkg::*;
    logic          sys_clk = 1'b0, rst = 1'b1;
    logic [6:0]    pool = 7'h00;
    logic          dg2 = 1'b0, dg1 = 1'b0, f4 = 1'b0, tle = 1'b0, otf = 1'b0, twv = 1'b0;
    logic          thn = 1'b1, gp6 = 1'b0, t25 = 1'b0, ids = 1'b0, p10s = 1'b0;
    logic [2:0]    fans = 3'h0;
    logic [4:0]    vid = 5'h00;
    lsal_pin4_type p4 = LSAL_PIN4_TACH;
    logic          rd, wr, a10_n, a14_n;
    logic [7:0]    addr, wdata, rdata, d;
    int            fails = 0, n_tests = 0;
    always #2 sys_clk = ~sys_clk;
    lsal_status dut_u (.sys_clk(sys_clk), .rst(rst), .primary_out_of_limit(pool), .remote_two_diode_fault(dg2),
        .remote_one_diode_fault(dg1), .fan_slow(fans), .fan_four_slow(f4), .thermal_limit_exceeded(tle),
        .overtemperature_flag(otf), .twelve_volt_out_of_limit(twv), .thermal_alarm_pin_n(thn),
        .general_purpose_pin_six(gp6), .voltage_id(vid), .thermal_on_volt25_pin(t25), .id_change_select(ids),
        .pin4_function(p4), .pin10_alert_select(p10s), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .pin10_alert_n(a10_n), .pin14_alert_n(a14_n));
    lsal_host host_u (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
        .reg_wdata(wdata));
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic sc_sticky();
        @(posedge sys_clk) pool <= 7'h28;
        @(posedge sys_clk) pool <= 7'h20;
        cyc(3);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("prim first", d, 8'h28);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("prim live", d, 8'h20);
        @(posedge sys_clk) pool <= 7'h00;
        cyc(3);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("prim sticky", d, 8'h20);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("prim clear", d, 8'h00);
    endtask
    task automatic sc_second();
        @(posedge sys_clk) {dg2, dg1, fans} <= 5'h1D;
        @(posedge sys_clk) {dg2, dg1, fans} <= 5'h00;
        cyc(3);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("pending", d, 8'h80);
        host_u.rd(LSAL_SECONDARY_OFFSET, d);
        chk("sec faults", d, 8'hD4);
        host_u.rd(LSAL_SECONDARY_OFFSET, d);
        chk("sec clear", d, 8'h00);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("pending off", d, 8'h00);
        host_u.rd(8'h43, d);
        chk("unmapped", d, 8'h00);
    endtask
    task automatic sc_ovt();
        @(posedge sys_clk) otf <= 1'b1;
        cyc(3);
        host_u.rd(LSAL_SECONDARY_OFFSET, d);
        chk("ovt on", d, 8'h02);
        @(posedge sys_clk) otf <= 1'b0;
        cyc(3);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("ovt gone", d, 8'h00);
    endtask
    task automatic sc_pins();
        @(posedge sys_clk) {t25, thn, gp6} <= 3'b101;
        p4 <= LSAL_PIN4_GENERAL;
        cyc(6);
        @(posedge sys_clk) {thn, gp6} <= 2'b10;
        cyc(6);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("alarm bit0", d, 8'h81);
        host_u.rd(LSAL_SECONDARY_OFFSET, d);
        chk("shared pin", d, 8'h20);
        @(posedge sys_clk) ids <= 1'b1;
        cyc(6);
        @(posedge sys_clk) vid <= 5'h0A;
        cyc(6);
        host_u.rd(LSAL_SECONDARY_OFFSET, d);
        chk("vid change", d, 8'h01);
    endtask
    task automatic sc_alert();
        @(posedge sys_clk) p10s <= 1'b1;
        host_u.wr(LSAL_MASK1_OFFSET, 8'h08);
        @(posedge sys_clk) pool <= 7'h08;
        @(posedge sys_clk) pool <= 7'h00;
        cyc(4);
        chk("alert masked", {7'h00, a10_n}, 8'h01);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("masked set", d, 8'h08);
        host_u.wr(LSAL_MASK1_OFFSET, 8'h00);
        @(posedge sys_clk) pool <= 7'h04;
        @(posedge sys_clk) pool <= 7'h00;
        cyc(4);
        chk("alert held", {7'h00, a10_n}, 8'h00);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("alert cause", d, 8'h04);
        cyc(3);
        chk("alert free", {7'h00, a10_n}, 8'h01);
    endtask
    // Shared pin functions, the second mask register and the second alert pin
    task automatic sc_shared();
        @(posedge sys_clk) p4 <= LSAL_PIN4_TACH;
        {t25, ids, f4, twv} <= 4'b0011;
        @(posedge sys_clk) {f4, twv} <= 2'b00;
        cyc(2);
        host_u.rd(LSAL_SECONDARY_OFFSET, d);
        chk("fan four", {7'h00, d[5]}, 8'h01);
        chk("twelve volt", {7'h00, d[0]}, 8'h01);
        @(posedge sys_clk) p4 <= LSAL_PIN4_THERMAL;
        tle <= 1'b1;
        @(posedge sys_clk) tle <= 1'b0;
        cyc(2);
        host_u.rd(LSAL_SECONDARY_OFFSET, d);
        chk("shared limit", d, 8'h20);
        host_u.wr(LSAL_MASK2_OFFSET, 8'h04);
        host_u.rd(LSAL_MASK2_OFFSET, d);
        chk("mask two", d, 8'h04);
        @(posedge sys_clk) p4 <= LSAL_PIN4_ALERT;
        p10s <= 1'b0;
        pool <= 7'h40;
        @(posedge sys_clk) pool <= 7'h00;
        cyc(3);
        chk("pin14 low", {6'h00, a14_n, a10_n}, 8'h01);
        host_u.rd(LSAL_PRIMARY_OFFSET, d);
        chk("remote two", d, 8'h40);
        cyc(3);
        chk("pin14 free", {6'h00, a14_n, a10_n}, 8'h03);
        @(posedge sys_clk) fans <= 3'h1;
        @(posedge sys_clk) fans <= 3'h0;
        cyc(3);
        chk("mask two gate", {6'h00, a14_n, a10_n}, 8'h03);
        host_u.wr(LSAL_MASK1_OFFSET, 8'h80);
        @(posedge sys_clk) fans <= 3'h2;
        @(posedge sys_clk) fans <= 3'h0;
        cyc(3);
        chk("pending mask", {6'h00, a14_n, a10_n}, 8'h03);
        host_u.rd(LSAL_SECONDARY_OFFSET, d);
        chk("masked fans", d, 8'h0C);
    endtask
    initial begin
        cyc(8);
        rst <= 1'b0;
        sc_sticky();
        sc_second();
        sc_ovt();
        sc_pins();
        sc_alert();
        sc_shared();
        final_report();
    end
    // Whole run is about 150 cycles; this is far beyond it
    initial begin
        #20000;
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
